// ===== sfc_consts.svh
// Timing, framing and clock-divider constants for the serial flash command host
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH
`define SFC_INSTR_BITS     8
`define SFC_ADDR24_BITS    24
`define SFC_ADDR32_BITS    32
`define SFC_MODE_BITS      8
`define SFC_SCK_HALF_DEF   5
`define SFC_FIFO_DEPTH_DEF 16
`define SFC_MAX_DUMMY      31
`endif

// ===== sfc_pkg.sv
// Types for the serial flash command host
package sfc_pkg;
   typedef enum logic [1:0] {
      SFC_W1 = 2'h0,
      SFC_W2 = 2'h1,
      SFC_W4 = 2'h2
   } sfc_width_t;

   typedef struct packed {
      logic [7:0]  instr;
      logic        skipInstr;
      logic        quadInstr;
      logic        hasAddr;
      logic        addr32;
      logic [31:0] addr;
      sfc_width_t  addrWidth;
      logic        hasMode;
      logic [7:0]  modeBits;
      logic [4:0]  dummy;
      logic        ddr;
      logic        isRead;
      logic        isWrite;
      logic [15:0] nBytes;
      logic        cpol;
   } sfc_cmd_t;

   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } sfc_lanes_t;
endpackage : sfc_pkg

// ===== sfc_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module sfc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wp;
      logic [AW:0]                 rp;
   } sfc_fifo_st_t;

   sfc_fifo_st_t st_r;
   sfc_fifo_st_t st_nxt;
   logic         full;
   logic         empty;

   assign full     = (st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
   assign empty    = (st_r.wp == st_r.rp);
   assign inReady  = !full;
   assign outValid = !empty;
   assign outData  = st_r.mem[st_r.rp[AW-1:0]];

   always_comb begin
      st_nxt = st_r;
      if (inValid && !full) begin
         st_nxt.mem[st_r.wp[AW-1:0]] = inData;
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (outReady && !empty) begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!reset_n)
      full && !outReady |=> full && $stable(st_r.wp))
      else $error("FIFO pointer moved while full");
endmodule : sfc_fifo

// ===== sfc_host.sv
// Host-side serial flash command controller driving clock, select and four lanes
`timescale 1ns/1ns
`include "sfc_consts.svh"

module sfc_host #(
   parameter int SCK_HALF   = `SFC_SCK_HALF_DEF,
   parameter int FIFO_DEPTH = `SFC_FIFO_DEPTH_DEF
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             cmdValid,
   output logic                  cmdReady,
   input  wire sfc_pkg::sfc_cmd_t cmd,
   input  wire logic             wrValid,
   output logic                  wrReady,
   input  wire logic [7:0]       wrData,
   output logic                  rdValid,
   input  wire logic             rdReady,
   output logic [7:0]            rdData,
   output logic                  busy,
   output logic                  sck,
   output logic                  selectN,
   output logic [3:0]            laneOut,
   output logic [3:0]            laneOe,
   input  wire logic [3:0]       laneIn
);
   initial begin
      if (SCK_HALF < 1 || SCK_HALF > 255) $error("SCK_HALF out of range");
   end

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_INSTR = 3'h1,
      ST_ADDR  = 3'h3,
      ST_MODE  = 3'h2,
      ST_DUMMY = 3'h6,
      ST_DATA  = 3'h7,
      ST_END   = 3'h5
   } sfc_state_t;

   typedef struct packed {
      sfc_state_t        state;
      sfc_pkg::sfc_cmd_t c;
      logic [7:0]        div;
      logic              sck;
      logic              selN;
      logic [31:0]       sh;
      logic [5:0]        bitsLeft;
      logic [15:0]       bytesLeft;
      sfc_pkg::sfc_width_t w;
      logic [3:0]        out;
      logic [3:0]        oe;
      logic [7:0]        rdSh;
      logic [3:0]        rdBits;
      logic [7:0]        rdByte;
      logic              rdPush;
      logic [3:0]        sync1;
      logic [3:0]        sync2;
   } sfc_st_t;

   sfc_st_t    st_r;
   sfc_st_t    st_nxt;
   logic       wrFifoValid;
   logic [7:0] wrFifoData;
   logic       wrPop;
   logic       rdFifoReady;

   function automatic logic [2:0] laneBits(input sfc_pkg::sfc_width_t w);
      unique case (w)
         sfc_pkg::SFC_W1: laneBits = 3'h1;
         sfc_pkg::SFC_W2: laneBits = 3'h2;
         sfc_pkg::SFC_W4: laneBits = 3'h4;
         default:         laneBits = 3'h1;
      endcase
   endfunction : laneBits

   // lowest bit of a group on lane0, group taken from the top of the shifter
   function automatic logic [3:0] topGroup(input logic [31:0] s, input sfc_pkg::sfc_width_t w);
      unique case (w)
         sfc_pkg::SFC_W1: topGroup = {3'h0, s[31]};
         sfc_pkg::SFC_W2: topGroup = {2'h0, s[31:30]};
         sfc_pkg::SFC_W4: topGroup = s[31:28];
         default:         topGroup = {3'h0, s[31]};
      endcase
   endfunction : topGroup

   function automatic logic [3:0] laneMask(input sfc_pkg::sfc_width_t w);
      unique case (w)
         sfc_pkg::SFC_W1: laneMask = 4'h1;
         sfc_pkg::SFC_W2: laneMask = 4'h3;
         sfc_pkg::SFC_W4: laneMask = 4'hF;
         default:         laneMask = 4'h1;
      endcase
   endfunction : laneMask

   sfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) uWrFifo (
      .clk      (clk),
      .reset_n  (reset_n),
      .inValid  (wrValid),
      .inReady  (wrReady),
      .inData   (wrData),
      .outValid (wrFifoValid),
      .outReady (wrPop),
      .outData  (wrFifoData)
   );

   sfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) uRdFifo (
      .clk      (clk),
      .reset_n  (reset_n),
      .inValid  (st_r.rdPush),
      .inReady  (rdFifoReady),
      .inData   (st_r.rdByte),
      .outValid (rdValid),
      .outReady (rdReady),
      .outData  (rdData)
   );

   logic halfTick;
   logic riseNow;
   logic fallNow;
   logic wrStall;
   logic rdStall;
   assign halfTick = (st_r.div == 8'(SCK_HALF - 1));
   assign riseNow  = halfTick && !st_r.sck;
   assign fallNow  = halfTick && st_r.sck;
   assign wrStall  = (st_r.state == ST_DATA) && st_r.c.isWrite && (st_r.bitsLeft == 6'h0)
                     && (st_r.bytesLeft != 16'h0) && !wrFifoValid;
   assign rdStall  = (st_r.state == ST_DATA) && st_r.c.isRead && !rdFifoReady;
   assign wrPop    = (st_r.state == ST_DATA) && st_r.c.isWrite && (st_r.bitsLeft == 6'h0)
                     && (st_r.bytesLeft != 16'h0) && wrFifoValid && st_r.sck && halfTick;

   assign cmdReady = (st_r.state == ST_IDLE);
   assign busy     = (st_r.state != ST_IDLE);
   assign sck      = st_r.sck;
   assign selectN  = st_r.selN;
   assign laneOut  = st_r.out;
   assign laneOe   = st_r.oe;

   always_comb begin
      logic       edgeDo;
      logic       shiftEdge;
      logic [2:0] lb;
      logic [3:0] g;
      st_nxt        = st_r;
      st_nxt.rdPush = 1'b0;
      st_nxt.sync1  = laneIn;
      st_nxt.sync2  = st_r.sync1;
      lb            = laneBits(st_r.w);
      g             = 4'h0;
      edgeDo        = 1'b0;
      shiftEdge     = 1'b0;
      unique case (st_r.state)
         ST_IDLE: begin
            // park the clock at the mode polarity
            st_nxt.sck  = cmd.cpol;
            st_nxt.selN = 1'b1;
            st_nxt.oe   = 4'h0;
            st_nxt.div  = 8'h0;
            if (cmdValid) begin
               st_nxt.c    = cmd;
               st_nxt.selN = 1'b0;
               // mode 3 idles high, mode 0 low
               st_nxt.sck  = cmd.cpol;
               // continuous read skips the instruction byte
               if (cmd.skipInstr) begin
                  st_nxt.state    = ST_ADDR;
                  st_nxt.sh       = cmd.addr32 ? cmd.addr : {cmd.addr[23:0], 8'h00};
                  st_nxt.bitsLeft = cmd.addr32 ? 6'd`SFC_ADDR32_BITS : 6'd`SFC_ADDR24_BITS;
                  st_nxt.w        = cmd.addrWidth;
               end else begin
                  st_nxt.state    = ST_INSTR;
                  st_nxt.sh       = {cmd.instr, 24'h000000};
                  st_nxt.bitsLeft = 6'd`SFC_INSTR_BITS;
                  // four-lane command mode widens the instruction
                  st_nxt.w        = cmd.quadInstr ? sfc_pkg::SFC_W4 : sfc_pkg::SFC_W1;
               end
               st_nxt.bytesLeft = cmd.nBytes;
               st_nxt.rdBits    = 4'h0;
               // mode 0 has no leading fall: first group goes out with select
               if (!cmd.cpol) begin
                  st_nxt.out      = topGroup(st_nxt.sh, st_nxt.w);
                  st_nxt.oe       = laneMask(st_nxt.w);
                  st_nxt.sh       = st_nxt.sh << laneBits(st_nxt.w);
                  st_nxt.bitsLeft = st_nxt.bitsLeft - 6'(laneBits(st_nxt.w));
               end
            end
         end
         ST_END: begin
            // select stays low until the last clock returns to idle level
            st_nxt.div = halfTick ? 8'h0 : st_r.div + 8'h1;
            if (halfTick) begin
               // Return the clock to its park level before select rises
               if (st_r.sck != st_r.c.cpol) begin
                  st_nxt.sck = st_r.c.cpol;
               end else begin
                  st_nxt.selN  = 1'b1;
                  st_nxt.oe    = 4'h0;
                  st_nxt.state = ST_IDLE;
               end
            end
         end
         default: begin
            if (!wrStall && !rdStall) begin
               st_nxt.div = halfTick ? 8'h0 : st_r.div + 8'h1;
               edgeDo     = halfTick;
            end
         end
      endcase

      if (edgeDo) begin
         st_nxt.sck = !st_r.sck;
         // host drives on falling edges, device samples on rising
         // double rate phases after the instruction shift on both edges
         shiftEdge = st_r.sck || (st_r.c.ddr && st_r.state != ST_INSTR && st_r.div != 8'hFF
                     && !(st_r.state == ST_DATA && st_r.c.isRead));
         if (fallNow || (shiftEdge && st_r.c.ddr && st_r.state != ST_INSTR)) begin
            if (st_r.bitsLeft != 6'h0 && st_r.state != ST_DUMMY
                && !(st_r.state == ST_DATA && st_r.c.isRead)) begin
               // single-width lane0 out; dual or quad groups
               g            = topGroup(st_r.sh, st_r.w);
               st_nxt.out   = g;
               st_nxt.oe    = laneMask(st_r.w);
               st_nxt.sh    = st_r.sh << lb;
               st_nxt.bitsLeft = st_r.bitsLeft - 6'(lb);
            end
         end
         // phases advance on falling edges, counted in bits, dummy counted in cycles
         if (fallNow && st_nxt.bitsLeft == 6'h0) begin
            unique case (st_r.state)
               ST_INSTR: begin
                  if (st_r.c.hasAddr) begin
                     st_nxt.state    = ST_ADDR;
                     st_nxt.sh       = st_r.c.addr32 ? st_r.c.addr : {st_r.c.addr[23:0], 8'h00};
                     st_nxt.bitsLeft = st_r.c.addr32 ? 6'd`SFC_ADDR32_BITS
                                                      : 6'd`SFC_ADDR24_BITS;
                     st_nxt.w        = st_r.c.addrWidth;
                  end else begin
                     st_nxt.state    = st_r.c.isRead ? ST_DUMMY : ST_DATA;
                     st_nxt.bitsLeft = st_r.c.isRead ? {1'b0, st_r.c.dummy} : 6'h0;
                  end
               end
               ST_ADDR: begin
                  if (st_r.c.hasMode) begin
                     st_nxt.state    = ST_MODE;
                     st_nxt.sh       = {st_r.c.modeBits, 24'h000000};
                     st_nxt.bitsLeft = 6'd`SFC_MODE_BITS;
                  end else begin
                     st_nxt.state    = ST_DUMMY;
                     st_nxt.bitsLeft = {1'b0, st_r.c.dummy};
                  end
               end
               ST_MODE: begin
                  st_nxt.state    = ST_DUMMY;
                  st_nxt.bitsLeft = {1'b0, st_r.c.dummy};
               end
               default: begin
               end
            endcase
            if (st_r.state == ST_DUMMY || (!st_r.c.isRead && st_r.c.dummy == 5'h0
                && (st_r.state == ST_MODE || (st_r.state == ST_ADDR && !st_r.c.hasMode)))) begin
               if (st_nxt.state == ST_DUMMY && st_nxt.bitsLeft != 6'h0) begin
                  st_nxt.oe = 4'h0;
               end else begin
                  // read data driven after the last latency falling edge
                  st_nxt.state = ST_DATA;
                  st_nxt.w     = st_r.c.addrWidth;
                  if (st_r.c.isRead) begin
                     st_nxt.oe = 4'h0;
                  end
               end
            end
         end
         // clock keeps toggling through dummy cycles
         if (fallNow && st_r.state == ST_DUMMY && st_r.bitsLeft != 6'h0) begin
            st_nxt.bitsLeft = st_r.bitsLeft - 6'h1;
            st_nxt.oe       = 4'h0;
         end
         // no-read command ends after the rise that takes its last bit
         if (riseNow && st_r.state == ST_DATA && !st_r.c.isRead && st_r.bitsLeft == 6'h0
             && (st_r.bytesLeft == 16'h0 || !st_r.c.isWrite)) begin
            st_nxt.state = ST_END;
         end
         // write data reloads from the FIFO each byte
         if (wrPop) begin
            st_nxt.sh        = {wrFifoData, 24'h000000};
            st_nxt.bitsLeft  = 6'h8;
            st_nxt.bytesLeft = st_r.bytesLeft - 16'h1;
            g               = topGroup({wrFifoData, 24'h000000}, st_r.w);
            st_nxt.out      = g;
            st_nxt.oe       = laneMask(st_r.w);
            st_nxt.sh       = {wrFifoData, 24'h000000} << lb;
            st_nxt.bitsLeft = 6'h8 - 6'(lb);
         end
         // read data sampled on rising edges, both edges in double rate
         if (st_r.state == ST_DATA && st_r.c.isRead && (riseNow || st_r.c.ddr)) begin
            unique case (st_r.w)
               sfc_pkg::SFC_W1: st_nxt.rdSh = {st_r.rdSh[6:0], st_r.sync2[1]};
               sfc_pkg::SFC_W2: st_nxt.rdSh = {st_r.rdSh[5:0], st_r.sync2[1:0]};
               default:         st_nxt.rdSh = {st_r.rdSh[3:0], st_r.sync2};
            endcase
            st_nxt.rdBits = st_r.rdBits + 4'(lb);
            if (st_r.rdBits + 4'(lb) == 4'h8) begin
               // bytes in address order, lowest first
               st_nxt.rdByte    = st_nxt.rdSh;
               st_nxt.rdPush    = 1'b1;
               st_nxt.rdBits    = 4'h0;
               st_nxt.bytesLeft = st_r.bytesLeft - 16'h1;
               // raise select after a whole byte
               if (st_r.bytesLeft == 16'h1) begin
                  st_nxt.state = ST_END;
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r      <= '0;
         st_r.selN <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // select low for the whole command
   a_select_held: assert property (@(posedge clk) disable iff (!reset_n)
      (st_r.state inside {ST_INSTR, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA}) |-> !selectN)
      else $error("Select high inside a command");
   a_idle_park: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(selectN) |-> sck == st_r.c.cpol)
      else $error("Clock not parked at mode level");
   a_write_boundary: assert property (@(posedge clk) disable iff (!reset_n)
      $past(st_r.state) == ST_DATA && st_r.state == ST_END && st_r.c.isWrite
      |-> st_r.bitsLeft == 6'h0)
      else $error("Write ended off a byte boundary");
   a_lanes_float: assert property (@(posedge clk) disable iff (!reset_n)
      selectN |=> laneOe == 4'h0 || !selectN)
      else $error("Lanes driven while deselected");
   a_dummy_release: assert property (@(posedge clk) disable iff (!reset_n)
      st_r.state == ST_DUMMY && st_r.bitsLeft != 6'h0 && fallNow |=> laneOe == 4'h0)
      else $error("Lanes driven in latency");
   a_instr_first: assert property (@(posedge clk) disable iff (!reset_n)
      $fell(selectN) && !st_r.c.skipInstr |-> st_r.state == ST_INSTR
      && st_r.bitsLeft == (st_r.c.cpol ? 6'h8 : 6'h8 - 6'(laneBits(st_r.w))))
      else $error("Command did not open with instruction");
   a_skip_instr: assert property (@(posedge clk) disable iff (!reset_n)
      $fell(selectN) && st_r.c.skipInstr |-> st_r.state == ST_ADDR)
      else $error("Continuous read sent instruction");
   a_drive_fall: assert property (@(posedge clk) disable iff (!reset_n)
      !st_r.c.ddr && $changed(laneOut) && !selectN |-> $fell(sck) || $fell(selectN))
      else $error("Lane changed off a falling edge");
endmodule : sfc_host

// ===== sfc_flash_model.sv
// Behavioural serial flash device answering the host on clock, select and four lanes
`timescale 1ns/1ns
module sfc_flash_model #(
   parameter logic [7:0] RD_OP     = 8'h11,
   parameter logic [7:0] WR_OP     = 8'h22,
   parameter logic [7:0] QRD_OP    = 8'h33,
   parameter logic [7:0] CONT_MODE = 8'hA5,
   parameter int         DUMMY     = 4
) (
   input  wire logic       sck,
   input  wire logic       selectN,
   input  wire logic [3:0] lanes,
   output logic [3:0]      devOut,
   output logic [3:0]      devOe,
   output int              badEnds
);
   logic [7:0]  mem [256];
   logic [7:0]  pend [$];
   logic [7:0]  op;
   logic [7:0]  modeSh;
   logic [7:0]  wb;
   logic [7:0]  byteNow;
   logic [23:0] addr;
   logic        contRd = 1'b0;
   int          n = 0;
   int          nI = 8;
   int          k;

   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
      devOut = 4'h0;
      devOe = 4'h0;
      badEnds = 0;
   end

   // Select fall opens a command, implied instruction in continuous read
   always @(negedge selectN) begin
      n = 0;
      nI = contRd ? 0 : 8;
      op = contRd ? QRD_OP : 8'h00;
      pend.delete();
   end

   always @(posedge sck) if (!selectN) begin
      k = n - nI;
      if (k < 0) op = {op[6:0], lanes[0]};
      else if (op == QRD_OP && k < 6) addr = {addr[19:0], lanes};
      else if (op == QRD_OP && k < 8) modeSh = {modeSh[3:0], lanes};
      else if (op != QRD_OP && k < 24) addr = {addr[22:0], lanes[0]};
      else if (op == WR_OP) begin
         wb = {wb[6:0], lanes[0]};
         if (k % 8 == 7) pend.push_back(wb);
      end
      n++;
   end

   // Falling-edge drive from the last latency cycle
   always @(negedge sck) if (!selectN) begin
      k = n - nI;
      if (op == RD_OP && k >= 24) begin
         byteNow = mem[8'(addr + 24'((k - 24) / 8))];
         devOut <= {2'b00, byteNow[7 - (k - 24) % 8], 1'b0};
         devOe <= 4'b0010;
      end else if (op == QRD_OP && k >= 8 + DUMMY) begin
         byteNow = mem[8'(addr + 24'((k - 8 - DUMMY) / 2))];
         devOut <= ((k - 8 - DUMMY) % 2 == 0) ? byteNow[7:4] : byteNow[3:0];
         devOe <= 4'hF;
      end
   end

   // Select rise floats lanes, keeps mode, commits whole writes
   always @(posedge selectN) begin
      devOe <= 4'h0;
      if (op == QRD_OP && n - nI >= 8) contRd = (modeSh == CONT_MODE);
      if (op != RD_OP && op != QRD_OP && n % 8 != 0) badEnds++;
      else if (op == WR_OP) foreach (pend[i]) mem[8'(addr + 24'(i))] = pend[i];
   end
endmodule : sfc_flash_model

// ===== sfc_tb.sv
// Self-checking bench for the serial flash command host
`timescale 1ns/1ns
module tb;
   localparam logic [7:0] RD   = 8'h11;
   localparam logic [7:0] WR   = 8'h22;
   localparam logic [7:0] QRD  = 8'h33;
   localparam logic [7:0] CONT = 8'hA5;
   logic              clk, reset_n, cmdValid, cmdReady, wrValid, wrReady;
   logic              rdValid, rdReady, busy, sck, selectN;
   logic              junk = 1'b0;
   logic [7:0]        wrData, rdData;
   logic [3:0]        laneOut, laneOe, laneIn, devOut, devOe;
   logic [7:0]        shadow [256];
   sfc_pkg::sfc_cmd_t cmd;
   int                err_count = 0;
   int                checks = 0;
   int                cycles = 0;
   int                badEnds;

   sfc_host #(.SCK_HALF(5), .FIFO_DEPTH(16)) i_sfc_host (
      .clk(clk), .reset_n(reset_n), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
      .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData), .rdValid(rdValid),
      .rdReady(rdReady), .rdData(rdData), .busy(busy), .sck(sck), .selectN(selectN),
      .laneOut(laneOut), .laneOe(laneOe), .laneIn(laneIn));
   sfc_flash_model #(.RD_OP(RD), .WR_OP(WR), .QRD_OP(QRD), .CONT_MODE(CONT), .DUMMY(4))
      i_sfc_flash_model (.sck(sck), .selectN(selectN), .lanes(laneIn), .devOut(devOut),
      .devOe(devOe), .badEnds(badEnds));

   // Released lanes: pull-ups on lanes 2 and 3, a changing pattern on lanes 0 and 1
   assign laneIn = (laneOe & laneOut) | (~laneOe & devOe & devOut)
                 | (~laneOe & ~devOe & {2'b11, junk, ~junk});

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   always @(posedge clk) begin
      junk <= ~junk;
      cycles <= cycles + 1;
      if (|(laneOe & devOe)) check(32'(laneOe & devOe), 32'h0, "lane contention");
      if (cycles == 30000) begin
         err_count = err_count + 1;
         $display("ERROR %0t run did not finish", $time);
         give_verdict();
      end
   end

   task automatic run_cmd(input logic [7:0] op, input logic [23:0] a,
                          input sfc_pkg::sfc_width_t w, input logic [7:0] mb, input logic skip,
                          input logic rd, input logic [15:0] n, input logic pol);
      sfc_pkg::sfc_cmd_t c;
      c = '0;
      c.instr = op;
      c.skipInstr = skip;
      c.hasAddr = 1'b1;
      c.addr = {8'h00, a};
      c.addrWidth = w;
      c.hasMode = (w == sfc_pkg::SFC_W4);
      c.modeBits = mb;
      c.dummy = (w == sfc_pkg::SFC_W4) ? 5'h04 : 5'h00;
      c.isRead = rd;
      c.isWrite = ~rd;
      c.nBytes = n;
      c.cpol = pol;
      cmd <= c;
      @(posedge clk);
      cmdValid <= 1'b1;
      @(posedge clk);
      cmdValid <= 1'b0;
      @(negedge clk);
      check(32'(selectN), 32'h0, "select low for the command");
      check(32'(sck), 32'(pol), "clock level at select fall");
      while (busy !== 1'b0) @(negedge clk);
      check(32'(sck), 32'(pol), "idle clock level");
      check(32'(selectN), 32'h1, "select released");
      @(posedge clk);
   endtask : run_cmd

   task automatic push_bytes(input int nb, input logic [7:0] base);
      for (int i = 0; i < nb; i++) begin
         wrData <= base + 8'(i);
         wrValid <= 1'b1;
         @(negedge clk);
         while (wrReady !== 1'b1) @(negedge clk);
         @(posedge clk);
      end
      wrValid <= 1'b0;
   endtask : push_bytes

   task automatic pop_bytes(input int nb, input int a);
      for (int i = 0; i < nb; i++) begin
         @(negedge clk);
         while (rdValid !== 1'b1) @(negedge clk);
         check(32'(rdData), 32'(shadow[8'(a + i)]), "read byte");
         @(posedge clk);
         rdReady <= 1'b1;
         @(posedge clk);
         rdReady <= 1'b0;
      end
   endtask : pop_bytes

   task automatic s_write_fill;
      push_bytes(16, 8'hC0);
      @(negedge clk);
      check(32'(wrReady), 32'h0, "full write buffer refuses");
      @(posedge clk);
      run_cmd(WR, 24'h000020, sfc_pkg::SFC_W1, 8'h00, 1'b0, 1'b0, 16'h0010, 1'b0);
      for (int i = 0; i < 16; i++) shadow[8'h20 + i] = 8'hC0 + 8'(i);
      check(32'(badEnds), 32'h0, "command ended off a byte boundary");
   endtask : s_write_fill

   task automatic s_read_stall;
      logic s;
      fork
         run_cmd(RD, 24'h000020, sfc_pkg::SFC_W1, 8'h00, 1'b0, 1'b1, 16'h0014, 1'b1);
         begin
            repeat (2500) @(posedge clk);
            s = sck;
            repeat (30) @(posedge clk);
            check(32'(sck), 32'(s), "clock holds on a full read buffer");
            check(32'(busy), 32'h1, "read stays open");
            pop_bytes(20, 32'h20);
         end
      join
      @(posedge clk);
      check(32'(rdValid), 32'h0, "read buffer drained");
   endtask : s_read_stall

   task automatic s_quad_cont;
      run_cmd(QRD, 24'h000021, sfc_pkg::SFC_W4, CONT, 1'b0, 1'b1, 16'h0003, 1'b0);
      pop_bytes(3, 32'h21);
      run_cmd(QRD, 24'h000040, sfc_pkg::SFC_W4, 8'h00, 1'b1, 1'b1, 16'h0002, 1'b1);
      pop_bytes(2, 32'h40);
      run_cmd(RD, 24'h000023, sfc_pkg::SFC_W1, 8'h00, 1'b0, 1'b1, 16'h0001, 1'b0);
      pop_bytes(1, 32'h23);
   endtask : s_quad_cont

   initial begin
      reset_n = 1'b0;
      cmdValid = 1'b0;
      cmd = '0;
      wrValid = 1'b0;
      wrData = 8'h00;
      rdReady = 1'b0;
      for (int i = 0; i < 256; i++) shadow[i] = 8'(i) ^ 8'h5A;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      s_write_fill();
      s_read_stall();
      s_quad_cont();
      give_verdict();
   end
endmodule : tb
